// file: ipls_pkg.sv
// Purpose: shared constants for start-up, park and light sequencing
// Assumes: 250 MHz system clock
// Notes: timing counts derive from printed times and the clock rate
package ipls_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int LED_DELAY_MS = 100;
  localparam int LED_DELAY_CYC = LED_DELAY_MS * (CLK_HZ / 1000);
  localparam int I2C_QUIET_MS = 100;
  localparam int I2C_QUIET_CYC = I2C_QUIET_MS * (CLK_HZ / 1000);
  localparam int PARK_WINDOW_US = 500;
  localparam int PARK_WINDOW_CYC = PARK_WINDOW_US * (CLK_HZ / 1_000_000);
  localparam int SCLK_HALF_CYC = 4;
  localparam int GPIO_PULSE_CYC = 16;
  localparam int CFG_BYTES = 4;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [7:0] AUX_STATUS_CMD = 8'h05;
  localparam logic [7:0] CFG_ADDR_BYTE = 8'h00;
  // arbitrary signature value marking a valid configuration image
  localparam logic [7:0] CFG_SIGNATURE = 8'h5A;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_DRV_BIT = 2;
  localparam logic [1:0] LIGHT_SEL_OFF = 2'h0;
  typedef enum {
    IPLS_WAIT, IPLS_FL_CMD, IPLS_FL_ADDR, IPLS_FL_READ,
    IPLS_AUX_CMD, IPLS_AUX_READ, IPLS_DONE_HI, IPLS_RUN
  } ipls_state_t;
endpackage

// file: ipls_spi_shift.sv
// Purpose: one-byte serial flash shifter, clock idle low
// Assumes: miso already synchronised; chip selects held by the caller
// Notes: data out changes on falling serial clock, data in taken on rising
`timescale 1ns/1ps
module ipls_spi_shift
  import ipls_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic done_out,
  output logic [7:0] rx_byte_out
);
  logic busy_r;
  logic [7:0] div_r;
  logic [2:0] bit_r;
  logic [7:0] tx_r;
  logic tick;

  assign tick = busy_r && (div_r == 8'(HALF - 1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
    end else if (!busy_r || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      sclk_out <= 1'b0;
      mosi_out <= 1'b0;
      bit_r <= 3'h0;
      tx_r <= 8'h00;
      rx_byte_out <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_r) begin
        busy_r <= 1'b1;
        tx_r <= {tx_byte_in[6:0], 1'b0};
        mosi_out <= tx_byte_in[7]; // [R10]
        bit_r <= 3'h0;
      end else if (tick && !sclk_out) begin
        sclk_out <= 1'b1;
        rx_byte_out <= {rx_byte_out[6:0], miso_in}; // [R11]
      end else if (tick) begin
        sclk_out <= 1'b0;
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
        end else begin
          mosi_out <= tx_r[7]; // [R10]
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  a_rx_after_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(sclk_out) |-> rx_byte_out[0] == $past(miso_in)) // [R11]
    else $error("serial input not captured on clock rise");
endmodule

// file: ipls_seq.sv
// Notes on behaviour
// R1 - configuration starts only after reset release
// R2 - six outputs undriven while reset held
// R3 - host raises park near reset release
// R4 - host lowers park before removing power
// R5 - light enable low forces driver off, select 00
// R6 - light outputs held off 100 ms after enable
// R7 - host waits 100 ms before bus traffic
// R8 - select 0 picks the serial flash
// R9 - select 1 picks the auxiliary serial device
// R10 - commands and data leave on serial out
// R11 - returned data captured on serial in
// R12 - pin 4 pulses on init done, then errors
// R13 - enable drop restarts the 100 ms delay
//
// Purpose: start-up configuration, park tracking and light output gating
// Assumes: park and light enable arrive asynchronously; reset is power-on
// Notes: the configuration image sets the normal light select and driver state
`timescale 1ns/1ps
module ipls_seq
  import ipls_pkg::*;
#(
  parameter int LED_DELAY_P = LED_DELAY_CYC,
  parameter int I2C_QUIET_P = I2C_QUIET_CYC,
  parameter int PARK_WINDOW_P = PARK_WINDOW_CYC,
  parameter int N_CFG = CFG_BYTES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic park_n_in,
  input wire logic light_source_enable_in,
  input wire logic serial_flash_miso_in,
  output logic mirror_power_enable_out,
  output logic mirror_power_enable_oe_out,
  output logic light_driver_on_out,
  output logic light_driver_on_oe_out,
  output logic [1:0] light_select_field_out,
  output logic light_select_field_oe_out,
  output logic serial_flash_clock_out,
  output logic serial_flash_clock_oe_out,
  output logic serial_flash_mosi_out,
  output logic serial_flash_mosi_oe_out,
  output logic flash_select_n_out,
  output logic flash_select_n_oe_out,
  output logic aux_device_select_n_out,
  output logic init_done_irq_pin_out,
  output logic i2c_quiet_done_out
);
  ipls_state_t state_r;
  logic [1:0] rel_r;
  logic [1:0] park_sy_r;
  logic [1:0] led_sy_r;
  logic [1:0] miso_sy_r;
  logic drive_r;
  logic [31:0] led_cnt_r;
  logic [31:0] quiet_cnt_r;
  logic [31:0] park_cnt_r;
  logic [7:0] pulse_cnt_r;
  logic [3:0] idx_r;
  logic start_r;
  logic [7:0] tx_r;
  logic sh_done;
  logic [7:0] sh_rx;
  logic [1:0] cfg_sel_r;
  logic cfg_drv_r;
  logic err_pend_r;
  logic park_err_r;
  logic released;
  logic park_hi;
  logic led_en;

  assign released = rel_r[1];
  assign park_hi = park_sy_r[1];
  assign led_en = led_sy_r[1];

  // release of the async reset is itself retimed before anything starts
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_r <= 2'h0;
    end else begin
      rel_r <= {rel_r[0], 1'b1}; // [R1]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      park_sy_r <= 2'h0;
      led_sy_r <= 2'h0;
      miso_sy_r <= 2'h0;
    end else begin
      park_sy_r <= {park_sy_r[0], park_n_in};
      led_sy_r <= {led_sy_r[0], light_source_enable_in};
      miso_sy_r <= {miso_sy_r[0], serial_flash_miso_in};
    end
  end

  // output enables come up only after release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= released; // [R2]
    end
  end

  assign mirror_power_enable_oe_out = drive_r;
  assign light_driver_on_oe_out = drive_r;
  assign light_select_field_oe_out = drive_r;
  assign serial_flash_clock_oe_out = drive_r;
  assign serial_flash_mosi_oe_out = drive_r;
  assign flash_select_n_oe_out = drive_r;

  ipls_spi_shift #(
    .HALF(SCLK_HALF_CYC)
  ) u_shift (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_r),
    .tx_byte_in(tx_r),
    .miso_in(miso_sy_r[1]),
    .sclk_out(serial_flash_clock_out),
    .mosi_out(serial_flash_mosi_out),
    .done_out(sh_done),
    .rx_byte_out(sh_rx)
  );

  // configuration sequence: flash read, then one status byte from aux device
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= IPLS_WAIT;
      idx_r <= 4'h0;
      start_r <= 1'b0;
      tx_r <= 8'h00;
      flash_select_n_out <= 1'b1;
      aux_device_select_n_out <= 1'b1;
      cfg_sel_r <= LIGHT_SEL_OFF;
      cfg_drv_r <= 1'b0;
      err_pend_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
      init_done_irq_pin_out <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (park_err_r) begin
        err_pend_r <= 1'b1;
      end
      case (state_r)
        IPLS_WAIT: begin
          if (released) begin // [R1]
            state_r <= IPLS_FL_CMD;
            flash_select_n_out <= 1'b0; // [R8]
            tx_r <= FLASH_READ_CMD;
            start_r <= 1'b1;
          end
        end
        IPLS_FL_CMD, IPLS_FL_ADDR: begin
          if (sh_done) begin
            tx_r <= CFG_ADDR_BYTE; // [R10]
            start_r <= 1'b1;
            idx_r <= idx_r + 4'h1;
            if (state_r == IPLS_FL_CMD) begin
              state_r <= IPLS_FL_ADDR;
              idx_r <= 4'h0;
            end else if (idx_r == 4'h2) begin
              state_r <= IPLS_FL_READ;
              idx_r <= 4'h0;
            end
          end
        end
        IPLS_FL_READ: begin
          if (sh_done) begin
            if (idx_r == 4'h0 && sh_rx != CFG_SIGNATURE) begin
              err_pend_r <= 1'b1;
            end
            if (idx_r == 4'h1) begin
              cfg_sel_r <= sh_rx[CFG_SEL_LSB +: 2];
              cfg_drv_r <= sh_rx[CFG_DRV_BIT];
            end
            idx_r <= idx_r + 4'h1;
            if (idx_r == 4'(N_CFG - 1)) begin
              state_r <= IPLS_AUX_CMD;
              flash_select_n_out <= 1'b1;
              aux_device_select_n_out <= 1'b0; // [R9]
              tx_r <= AUX_STATUS_CMD;
            end
            start_r <= 1'b1;
          end
        end
        IPLS_AUX_CMD: begin
          if (sh_done) begin
            state_r <= IPLS_AUX_READ;
            tx_r <= 8'h00;
            start_r <= 1'b1;
          end
        end
        IPLS_AUX_READ: begin
          if (sh_done) begin
            aux_device_select_n_out <= 1'b1;
            if (sh_rx != 8'h00) begin
              err_pend_r <= 1'b1;
            end
            state_r <= IPLS_DONE_HI;
            init_done_irq_pin_out <= 1'b1; // [R12]
            pulse_cnt_r <= 8'h00;
          end
        end
        IPLS_DONE_HI: begin
          pulse_cnt_r <= pulse_cnt_r + 8'h01;
          if (pulse_cnt_r == 8'(GPIO_PULSE_CYC - 1)) begin
            init_done_irq_pin_out <= 1'b0; // [R12]
            state_r <= IPLS_RUN;
            pulse_cnt_r <= 8'h00;
          end
        end
        IPLS_RUN: begin
          // error pulses follow the done pulse, one at a time, low gap between
          if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r + 8'h01;
            if (pulse_cnt_r == 8'(2 * GPIO_PULSE_CYC - 1)) begin
              pulse_cnt_r <= 8'h00;
            end
            if (pulse_cnt_r == 8'(GPIO_PULSE_CYC)) begin
              init_done_irq_pin_out <= 1'b0; // [R12]
            end
          end else if (err_pend_r && !park_err_r) begin
            err_pend_r <= 1'b0;
            init_done_irq_pin_out <= 1'b1; // [R12]
            pulse_cnt_r <= 8'h01;
          end
        end
        default: state_r <= IPLS_WAIT;
      endcase
    end
  end

  // park must be high by the window's end; a late park is flagged as an error
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      park_cnt_r <= 32'h0;
      park_err_r <= 1'b0;
    end else begin
      park_err_r <= 1'b0;
      if (released && park_cnt_r <= 32'(PARK_WINDOW_P)) begin
        park_cnt_r <= park_cnt_r + 32'h1;
        if (park_cnt_r == 32'(PARK_WINDOW_P) && !park_hi) begin
          park_err_r <= 1'b1; // [R3]
        end
      end
    end
  end

  // mirrors powered only in normal operation with park high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mirror_power_enable_out <= 1'b0;
    end else begin
      mirror_power_enable_out <= park_hi && state_r == IPLS_RUN; // [R4]
    end
  end

  // bus quiet time measured from both park and reset high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_cnt_r <= 32'h0;
      i2c_quiet_done_out <= 1'b0;
    end else if (!(released && park_hi)) begin
      quiet_cnt_r <= 32'h0;
      i2c_quiet_done_out <= 1'b0;
    end else if (quiet_cnt_r < 32'(I2C_QUIET_P)) begin
      quiet_cnt_r <= quiet_cnt_r + 32'h1;
    end else begin
      i2c_quiet_done_out <= 1'b1; // [R7]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_cnt_r <= 32'h0;
    end else begin
      if (!led_en) begin
        led_cnt_r <= 32'h0; // [R13]
      end else if (led_cnt_r < 32'(LED_DELAY_P)) begin
        led_cnt_r <= led_cnt_r + 32'h1; // [R6]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      light_driver_on_out <= 1'b0;
      light_select_field_out <= LIGHT_SEL_OFF;
    end else if (!led_en || led_cnt_r < 32'(LED_DELAY_P) || state_r != IPLS_RUN) begin
      light_driver_on_out <= 1'b0; // [R5] [R6]
      light_select_field_out <= LIGHT_SEL_OFF;
    end else begin
      light_driver_on_out <= cfg_drv_r;
      light_select_field_out <= cfg_sel_r;
    end
  end

  // length of the current high stretch on pin 4, read only by the pulse check
  logic [7:0] pin_hi_cnt_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_hi_cnt_r <= 8'h00;
    end else if (init_done_irq_pin_out) begin
      pin_hi_cnt_r <= pin_hi_cnt_r + 8'h01;
    end else begin
      pin_hi_cnt_r <= 8'h00;
    end
  end

  a_oe_while_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !released |-> !drive_r && !mirror_power_enable_oe_out) // [R2]
    else $error("outputs driven before release");
  a_cfg_not_early: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !released |=> state_r == IPLS_WAIT && flash_select_n_out) // [R1]
    else $error("configuration began before release");
  a_light_forced_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !led_en |=> !light_driver_on_out && light_select_field_out == 2'h0) // [R5]
    else $error("light outputs not forced off");
  a_light_delay_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    led_cnt_r < 32'(LED_DELAY_P) |=> !light_driver_on_out) // [R6]
    else $error("light driver released before delay");
  a_light_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(led_en) |=> led_cnt_r == 32'h0 ##1 !light_driver_on_out) // [R13]
    else $error("light delay not restarted");
  a_flash_sel_excl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !flash_select_n_out |-> aux_device_select_n_out) // [R8]
    else $error("both selects active");
  a_aux_sel_phase: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !aux_device_select_n_out |-> state_r inside {IPLS_AUX_CMD, IPLS_AUX_READ}) // [R9]
    else $error("aux select outside its phase");
  a_mosi_high_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    serial_flash_clock_out && $past(serial_flash_clock_out)
      |-> $stable(serial_flash_mosi_out)) // [R10]
    else $error("serial out moved while clock high");
  a_done_pulse_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(state_r == IPLS_DONE_HI) |-> init_done_irq_pin_out) // [R12]
    else $error("init done pulse did not start");
  a_done_pulse_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(init_done_irq_pin_out) |-> pin_hi_cnt_r == 8'(GPIO_PULSE_CYC)) // [R12]
    else $error("pin 4 pulse wrong length");
  a_quiet_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    i2c_quiet_done_out |-> $past(park_hi) && $past(quiet_cnt_r) == 32'(I2C_QUIET_P)) // [R7]
    else $error("quiet flag set early");

  c_init_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(init_done_irq_pin_out) && state_r == IPLS_RUN);
  c_light_on: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(light_driver_on_out));
  c_error_pulse: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == IPLS_RUN && $rose(init_done_irq_pin_out));
  c_quiet_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(i2c_quiet_done_out));
endmodule

// file: ipls_spi_partner.sv
// Purpose: serial flash and auxiliary device on the shared serial bus
// Assumes: clock idle low, data msb first, one transfer per select
// Notes: a released data line toggles each cycle so stale bits never pass
`timescale 1ns/1ps
module ipls_spi_partner (
  input wire logic clk_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic flash_select_n_in,
  input wire logic aux_device_select_n_in,
  input wire logic [7:0] sig_in,
  input wire logic [7:0] cfg_in,
  input wire logic [7:0] stat_in,
  output logic miso_out,
  output logic [31:0] flash_cmd_out,
  output logic [7:0] aux_cmd_out
);
  int fcnt_r = 0;
  int acnt_r = 0;
  logic fbit_r = 1'b0;
  logic abit_r = 1'b0;
  logic idle_r = 1'b0;
  logic [7:0] fbyte;
  logic [7:0] abyte;
  always @(posedge clk_in) idle_r <= ~idle_r;
  always @(posedge sclk_in or posedge flash_select_n_in) begin
    if (flash_select_n_in) begin
      fcnt_r <= 0;
    end else begin
      if (fcnt_r < 32) flash_cmd_out <= {flash_cmd_out[30:0], mosi_in};
      fcnt_r <= fcnt_r + 1;
    end
  end
  always @(posedge sclk_in or posedge aux_device_select_n_in) begin
    if (aux_device_select_n_in) begin
      acnt_r <= 0;
    end else begin
      if (acnt_r < 8) aux_cmd_out <= {aux_cmd_out[6:0], mosi_in};
      acnt_r <= acnt_r + 1;
    end
  end
  always_comb begin
    case (fcnt_r / 8)
      4: fbyte = sig_in;
      5: fbyte = cfg_in;
      default: fbyte = 8'h00;
    endcase
    abyte = (acnt_r / 8 == 1) ? stat_in : 8'h00;
  end
  // answer bits move on the falling clock, well ahead of the next rise
  always @(negedge sclk_in or negedge flash_select_n_in) fbit_r <= fbyte[~fcnt_r[2:0]];
  always @(negedge sclk_in or negedge aux_device_select_n_in) abit_r <= abyte[~acnt_r[2:0]];
  assign miso_out = !flash_select_n_in ? fbit_r : (!aux_device_select_n_in ? abit_r : idle_r);
endmodule

// file: tb_ipls_seq.sv
// Purpose: self-checking bench for start-up, light gating and quiet flag
// Assumes: short delay parameters stand in for the 100 ms and 500 us counts
// Notes: inputs change at the falling clock edge
`timescale 1ns/1ps
module tb_ipls_seq;
  import ipls_pkg::*;
  localparam int LD = 50;
  localparam int QD = 50;
  localparam int PW = 20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic park_n_in = 1'b1;
  logic light_source_enable_in = 1'b0;
  logic miso, mpe, mpe_oe, drv, drv_oe, sel_oe, sclk, sclk_oe, mosi, mosi_oe;
  logic fsel, fsel_oe, asel, pin4, quiet;
  logic [1:0] sel;
  logic [7:0] sig = CFG_SIGNATURE;
  logic [7:0] cfg = 8'h06;
  logic [7:0] stat = 8'h00;
  logic [31:0] fcmd;
  logic [7:0] acmd;
  int err_total = 0;
  int checks = 0;
  always #2 clk_in = ~clk_in;
  ipls_seq #(.LED_DELAY_P(LD), .I2C_QUIET_P(QD), .PARK_WINDOW_P(PW), .N_CFG(CFG_BYTES)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .park_n_in(park_n_in),
    .light_source_enable_in(light_source_enable_in), .serial_flash_miso_in(miso),
    .mirror_power_enable_out(mpe), .mirror_power_enable_oe_out(mpe_oe),
    .light_driver_on_out(drv), .light_driver_on_oe_out(drv_oe),
    .light_select_field_out(sel), .light_select_field_oe_out(sel_oe),
    .serial_flash_clock_out(sclk), .serial_flash_clock_oe_out(sclk_oe),
    .serial_flash_mosi_out(mosi), .serial_flash_mosi_oe_out(mosi_oe),
    .flash_select_n_out(fsel), .flash_select_n_oe_out(fsel_oe),
    .aux_device_select_n_out(asel), .init_done_irq_pin_out(pin4),
    .i2c_quiet_done_out(quiet));
  ipls_spi_partner partner (.clk_in(clk_in), .sclk_in(sclk), .mosi_in(mosi),
    .flash_select_n_in(fsel), .aux_device_select_n_in(asel), .sig_in(sig),
    .cfg_in(cfg), .stat_in(stat), .miso_out(miso), .flash_cmd_out(fcmd),
    .aux_cmd_out(acmd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return fsel;
      1: return pin4;
      2: return drv;
      default: return quiet;
    endcase
  endfunction
  // bounded wait for a watched output to reach a level
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic t_reset();
    int n;
    park_n_in = 1'b0; // park well before supplies go
    if (rst_n_in === 1'b1) begin
      cyc(PW + 5);
    end
    rst_n_in = 1'b0;
    cyc(20);
    chk({mpe_oe, drv_oe, sel_oe, sclk_oe, mosi_oe, fsel_oe}, 0);
    chk({fsel, asel, sclk}, 3'b110);
    park_n_in = 1'b1;
    cyc(1);
    rst_n_in = 1'b1;
    cyc(1);
    chk(fsel, 1);
    wait_for(0, 1'b0, 10, n);
    chk(n < 10, 1);
    chk(mpe_oe & drv_oe & sel_oe & sclk_oe & mosi_oe & fsel_oe, 1);
    $display("test reset done");
  endtask
  task automatic t_init(input logic bad);
    int n;
    wait_for(1, 1'b1, 3000, n);
    chk(n < 3000, 1);
    chk(fcmd, {FLASH_READ_CMD, {3{CFG_ADDR_BYTE}}});
    chk(acmd, AUX_STATUS_CMD);
    wait_for(1, 1'b0, 40, n);
    chk(n, GPIO_PULSE_CYC);
    wait_for(1, 1'b1, 100, n);
    chk(n < 100, bad);
    if (bad) begin
      wait_for(1, 1'b0, 40, n);
      chk(n, GPIO_PULSE_CYC);
    end
    chk(mpe, 1);
    $display("test init done");
  endtask
  task automatic t_light();
    int n;
    light_source_enable_in = 1'b0;
    cyc(4);
    chk({drv, sel}, 3'b000);
    light_source_enable_in = 1'b1;
    cyc(LD - 5);
    chk({drv, sel}, 3'b000);
    wait_for(2, 1'b1, 20, n);
    chk({drv, sel}, {cfg[CFG_DRV_BIT], cfg[CFG_SEL_LSB +: 2]});
    light_source_enable_in = 1'b0;
    cyc(4);
    chk({drv, sel}, 3'b000);
    light_source_enable_in = 1'b1;
    cyc(LD / 2);
    light_source_enable_in = 1'b0;
    cyc(4);
    chk({drv, sel}, 3'b000);
    light_source_enable_in = 1'b1;
    cyc(LD - 5);
    chk({drv, sel}, 3'b000);
    wait_for(2, 1'b1, 20, n);
    chk(n < 20, 1);
    $display("test light done");
  endtask
  task automatic t_quiet();
    int n;
    park_n_in = 1'b0;
    cyc(5);
    chk(quiet, 0);
    chk(mpe, 0);
    park_n_in = 1'b1;
    cyc(QD - 5);
    chk(quiet, 0);
    wait_for(3, 1'b1, 20, n);
    chk(n < 20, 1);
    chk(mpe, 1);
    $display("test quiet done");
  endtask
  // park raised only after the window: the device must flag an error pulse
  task automatic t_park_late();
    park_n_in = 1'b0;
    cyc(PW + 5);
    rst_n_in = 1'b0;
    cyc(20);
    rst_n_in = 1'b1;
    cyc(PW + 5);
    chk(quiet, 0);
    park_n_in = 1'b1; // raised after the window
    t_init(1'b1);
    $display("test park late done");
  endtask
  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_init(1'b0);
    t_light();
    t_quiet();
    sig = ~CFG_SIGNATURE;
    t_reset();
    t_init(1'b1);
    sig = CFG_SIGNATURE;
    stat = 8'h01;
    t_reset();
    t_init(1'b1);
    stat = 8'h00;
    t_park_late();
    summarize();
  end
  // roughly fifteen times the expected run
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule
